// *** hdl/ratio_current_ratio_element_trip.sv ***
// Purpose: three-phase ratio differential trip element with APB settings
// Assumes: phasors arrive with SAMPLE_VALID_I on the CLK_I domain
// Notes: interlock pins are asynchronous; timers run in 10 ms ticks
//
// Contract
// - Differential is magnitude of neutral minus output phasor, plus restraint.
// - Restraint is larger, smaller, or phasor sum magnitude by method.
// - Operate only when slope ratio and minimum current both satisfied.
// - Low region: difference percent of restraint at least low slope.
// - High region: slope two past break, offset by slope one times break.
// - Break current between regions is set from 0.4 to 10.0 A.
// - Output asserts after condition persists for operate delay 0 to 10 s.
// - Instantaneous setting gives output within 50 ms.
// - Output held 200 ms after condition clears.
// - Use setting off means no output at all; PHASE_OP_O still gives the phase decisions.
// - Two external interlock inputs block operation.
// - Six current inputs, separate differential evaluation per phase.
`timescale 1ns/1ps
`default_nettype none
module ratio_current_ratio_element_trip
  import ratio_current_ratio_element_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [DATA_W-1:0] PWDATA_I,
  output logic [DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [CUR_W-1:0] I1A_RE_I,
  input wire logic signed [CUR_W-1:0] I1A_IM_I,
  input wire logic signed [CUR_W-1:0] I1B_RE_I,
  input wire logic signed [CUR_W-1:0] I1B_IM_I,
  input wire logic signed [CUR_W-1:0] I1C_RE_I,
  input wire logic signed [CUR_W-1:0] I1C_IM_I,
  input wire logic signed [CUR_W-1:0] I2A_RE_I,
  input wire logic signed [CUR_W-1:0] I2A_IM_I,
  input wire logic signed [CUR_W-1:0] I2B_RE_I,
  input wire logic signed [CUR_W-1:0] I2B_IM_I,
  input wire logic signed [CUR_W-1:0] I2C_RE_I,
  input wire logic signed [CUR_W-1:0] I2C_IM_I,
  input wire logic INTERLOCK1_I,
  input wire logic INTERLOCK2_I,
  output logic [PHASES-1:0] PHASE_OP_O,
  output logic TRIP_O,
  output logic IRQ_O
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_ON = 4'b0100,
    ST_HOLD = 4'b1000
  } trip_st_e;

  // ----------------------------------------------------------------
  // Per-phase evaluation
  // ----------------------------------------------------------------
  logic signed [CUR_W-1:0] n_re [PHASES];
  logic signed [CUR_W-1:0] n_im [PHASES];
  logic signed [CUR_W-1:0] o_re [PHASES];
  logic signed [CUR_W-1:0] o_im [PHASES];
  logic [PHASES-1:0] ph_op;
  logic use_q;
  logic [1:0] meth_q;
  logic [3:0] opcur_q;
  logic [5:0] k1_q, k2_q;
  logic [6:0] brk_q;
  logic [DLY_W-1:0] dly_q;

  // Neutral side is the inflow current, output side the outflow
  assign n_re[0] = I2A_RE_I;
  assign n_im[0] = I2A_IM_I;
  assign n_re[1] = I2B_RE_I;
  assign n_im[1] = I2B_IM_I;
  assign n_re[2] = I2C_RE_I;
  assign n_im[2] = I2C_IM_I;
  assign o_re[0] = I1A_RE_I;
  assign o_im[0] = I1A_IM_I;
  assign o_re[1] = I1B_RE_I;
  assign o_im[1] = I1B_IM_I;
  assign o_re[2] = I1C_RE_I;
  assign o_im[2] = I1C_IM_I;

  for (genvar p = 0; p < PHASES; p++) begin : g_ph
    ratio_phase_eval ratio_phase_eval_i (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .start_i(SAMPLE_VALID_I),
      .neu_re_i(n_re[p]),
      .neu_im_i(n_im[p]),
      .out_re_i(o_re[p]),
      .out_im_i(o_im[p]),
      .meth_i(meth_q),
      .opcur_i(opcur_q),
      .k1_i(k1_q),
      .k2_i(k2_q),
      .brk_i(brk_q),
      .op_o(ph_op[p])
    );
  end
  assign PHASE_OP_O = ph_op;

  // ----------------------------------------------------------------
  // Interlock pins
  // ----------------------------------------------------------------
  logic [1:0] lk_s1_q, lk_s2_q, lk_s3_q, lk_q;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      lk_s1_q <= '0;
      lk_s2_q <= '0;
      lk_s3_q <= '0;
      lk_q <= '0;
    end else begin
      lk_s1_q <= {INTERLOCK2_I, INTERLOCK1_I};
      lk_s2_q <= lk_s1_q;
      lk_s3_q <= lk_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (lk_s2_q[i] == lk_s3_q[i]) begin
          lk_q[i] <= lk_s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Operate and off-delay timing
  // ----------------------------------------------------------------
  logic any_op, op_gate, timing, tick;
  trip_st_e st_q, st_d;
  logic [TICK_W-1:0] pre_q, pre_d;
  logic [DLY_W-1:0] cnt_q, cnt_d, cnt_inc;
  logic trip_q;

  assign any_op = |ph_op;
  assign op_gate = use_q & ~|lk_q & any_op;
  assign timing = (st_q == ST_DELAY) || (st_q == ST_HOLD);
  assign tick = pre_q == TICK_W'(TICK_CYCLES - 1);
  assign cnt_inc = cnt_q + DLY_W'(1);

  always_comb begin
    st_d = st_q;
    cnt_d = tick ? cnt_inc : cnt_q;
    case (st_q)
      ST_IDLE: begin
        cnt_d = '0;
        if (op_gate) begin
          st_d = (dly_q == '0) ? ST_ON : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!op_gate) begin
          st_d = ST_IDLE;
        end else if (tick && cnt_inc >= dly_q) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        cnt_d = '0;
        if (!op_gate) begin
          st_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (op_gate) begin
          st_d = ST_ON;
        end else if (tick && cnt_inc >= DLY_W'(OFF_DELAY_TICKS)) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (!use_q) begin
      st_d = ST_IDLE;
    end
  end

  // Restarting the prescaler keeps each delay a full number of ticks
  assign pre_d = (timing && !tick && st_d == st_q) ?
                 pre_q + TICK_W'(1) : '0;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_q <= ST_IDLE;
      pre_q <= '0;
      cnt_q <= '0;
      trip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      trip_q <= (st_d == ST_ON) || (st_d == ST_HOLD);
    end
  end
  assign TRIP_O = trip_q;

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] evt_q, evt_en_q, evt_set, evt_clr;
  logic irq_q, trip_d1_q;
  assign evt_set[EVT_TRIP_ON] = trip_q & ~trip_d1_q;
  assign evt_set[EVT_TRIP_OFF] = ~trip_q & trip_d1_q;
  assign evt_set[EVT_BLOCKED] = use_q & any_op & |lk_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup, wr_en, pready_q, pslverr_q;
  logic [DATA_W-1:0] prdata_q, rd_mux;
  logic hit_ctrl, hit_opc, hit_slope, hit_brk, hit_dly;
  logic hit_stat, hit_evt, hit_clr, hit_en, mapped;

  assign setup = PSEL_I & ~PENABLE_I;
  assign wr_en = PSEL_I & PENABLE_I & pready_q & PWRITE_I;
  assign hit_ctrl = PADDR_I == OFS_CTRL;
  assign hit_opc = PADDR_I == OFS_OPCUR;
  assign hit_slope = PADDR_I == OFS_SLOPE;
  assign hit_brk = PADDR_I == OFS_BREAK;
  assign hit_dly = PADDR_I == OFS_DELAY;
  assign hit_stat = PADDR_I == OFS_STAT;
  assign hit_evt = PADDR_I == OFS_EVT;
  assign hit_clr = PADDR_I == OFS_EVT_CLR;
  assign hit_en = PADDR_I == OFS_EVT_EN;
  assign mapped = hit_ctrl | hit_opc | hit_slope | hit_brk | hit_dly |
                  hit_stat | hit_evt | hit_clr | hit_en;
  assign evt_clr = (wr_en && hit_clr) ? PWDATA_I[EVT_W-1:0] : '0;

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux[CTRL_USE] = use_q;
      rd_mux[CTRL_METH_LSB +: 2] = meth_q;
    end else if (hit_opc) begin
      rd_mux[3:0] = opcur_q;
    end else if (hit_slope) begin
      rd_mux[5:0] = k1_q;
      rd_mux[SLOPE_K2_LSB +: 6] = k2_q;
    end else if (hit_brk) begin
      rd_mux[6:0] = brk_q;
    end else if (hit_dly) begin
      rd_mux[DLY_W-1:0] = dly_q;
    end else if (hit_stat) begin
      rd_mux[PHASES-1:0] = ph_op;
      rd_mux[STAT_TRIP] = trip_q;
      rd_mux[STAT_LOCK_LSB +: 2] = lk_q;
    end else if (hit_evt) begin
      rd_mux[EVT_W-1:0] = evt_q;
    end else if (hit_en) begin
      rd_mux[EVT_W-1:0] = evt_en_q;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !PWRITE_I) begin
        prdata_q <= rd_mux;
      end
    end
  end
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      use_q <= 1'b0;
      meth_q <= METH_MAX;
      opcur_q <= RST_OPCUR;
      k1_q <= RST_K1;
      k2_q <= RST_K2;
      brk_q <= RST_BREAK;
      dly_q <= RST_DELAY;
      evt_en_q <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        use_q <= PWDATA_I[CTRL_USE];
        meth_q <= PWDATA_I[CTRL_METH_LSB +: 2];
      end
      if (hit_opc) opcur_q <= PWDATA_I[3:0];
      if (hit_slope) begin
        k1_q <= PWDATA_I[5:0];
        k2_q <= PWDATA_I[SLOPE_K2_LSB +: 6];
      end
      if (hit_brk) brk_q <= PWDATA_I[6:0];
      if (hit_dly) dly_q <= PWDATA_I[DLY_W-1:0];
      if (hit_en) evt_en_q <= PWDATA_I[EVT_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      evt_q <= '0;
      trip_d1_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      trip_d1_q <= trip_q;
      irq_q <= |(evt_q & evt_en_q);
    end
  end
  assign IRQ_O = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_use_off;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    !use_q |=> !TRIP_O;
  endproperty
  a_use_off: assert property (p_use_off)
    else $error("trip output while element unused");

  property p_instantaneous_setting;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    st_q == ST_IDLE && op_gate && dly_q == '0 |=> TRIP_O;
  endproperty
  a_instantaneous_setting: assert property (p_instantaneous_setting)
    else $error("instantaneous trip late");

  property p_rise;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(TRIP_O) |-> $past(op_gate) &&
      ($past(dly_q) == '0 || $past(cnt_inc) >= $past(dly_q));
  endproperty
  a_rise: assert property (p_rise)
    else $error("trip before operate delay");

  property p_hold;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    $fell(TRIP_O) |-> !$past(use_q) ||
      ($past(tick) && $past(cnt_inc) >= DLY_W'(OFF_DELAY_TICKS));
  endproperty
  a_hold: assert property (p_hold)
    else $error("trip released before off delay");

  property p_lock;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    |lk_q && st_q == ST_IDLE |=> !TRIP_O;
  endproperty
  a_lock: assert property (p_lock)
    else $error("trip despite interlock");

  property p_or;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    use_q && !(|lk_q) && |PHASE_OP_O && st_q == ST_IDLE
      |=> st_q != ST_IDLE;
  endproperty
  a_or: assert property (p_or)
    else $error("phase operation not timed");

  property p_ready;
    @(posedge CLK_I) disable iff (SYS_RST_I)
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready held more than one cycle");
endmodule
`default_nettype wire

// *** inc/ratio_current_ratio_element_pkg.sv ***
// Purpose: constants and helpers of the ratio differential trip element
// Assumes: currents in 0.01 A, current settings in 0.1 A, delay in 10 ms
// Notes: one tick of the element timers is TICK_MS long
package ratio_current_ratio_element_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CUR_W = 16;
  localparam int SQ_W = 2 * CUR_W + 4;
  localparam int MAG_W = SQ_W / 2;
  localparam int WIDE_W = 32;
  localparam int PHASES = 3;
  localparam int PCT_FULL = 100;
  localparam int DECI_TO_CENTI = 10;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;
  localparam int TICK_W = 21;
  localparam int OFF_DELAY_MS = 200;
  localparam int OFF_DELAY_TICKS = OFF_DELAY_MS / TICK_MS;
  localparam int FAST_TRIP_MS = 50;
  localparam int DLY_W = 10;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_OPCUR = 12'h004;
  localparam logic [11:0] OFS_SLOPE = 12'h008;
  localparam logic [11:0] OFS_BREAK = 12'h00C;
  localparam logic [11:0] OFS_DELAY = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_EVT = 12'h018;
  localparam logic [11:0] OFS_EVT_CLR = 12'h01C;
  localparam logic [11:0] OFS_EVT_EN = 12'h020;
  localparam int CTRL_USE = 0;
  localparam int CTRL_METH_LSB = 1;
  localparam int SLOPE_K2_LSB = 8;
  localparam int STAT_TRIP = 3;
  localparam int STAT_LOCK_LSB = 4;
  localparam int EVT_W = 3;
  localparam int EVT_TRIP_ON = 0;
  localparam int EVT_TRIP_OFF = 1;
  localparam int EVT_BLOCKED = 2;
  localparam logic [1:0] METH_MAX = 2'h0;
  localparam logic [1:0] METH_MIN = 2'h1;
  localparam logic [1:0] METH_SUM = 2'h2;
  localparam logic [3:0] RST_OPCUR = 4'h4;
  localparam logic [5:0] RST_K1 = 6'h05;
  localparam logic [5:0] RST_K2 = 6'h05;
  localparam logic [6:0] RST_BREAK = 7'h0A;
  localparam logic [DLY_W-1:0] RST_DELAY = 10'h000;

  function automatic logic [SQ_W-1:0] sq_mag(
    input logic signed [CUR_W:0] re,
    input logic signed [CUR_W:0] im);
    // Widen before squaring so the product keeps all its bits
    return $unsigned(SQ_W'(re) * SQ_W'(re)) +
      $unsigned(SQ_W'(im) * SQ_W'(im));
  endfunction

  function automatic logic [MAG_W-1:0] isqrt(input logic [SQ_W-1:0] v);
    logic [MAG_W-1:0] res;
    logic [MAG_W-1:0] trial;
    res = '0;
    for (int i = MAG_W - 1; i >= 0; i--) begin
      trial = res;
      trial[i] = 1'b1;
      if (SQ_W'(trial) * SQ_W'(trial) <= v) begin
        res = trial;
      end
    end
    return res;
  endfunction
endpackage

// *** hdl/ratio_phase_eval.sv ***
// Purpose: one phase of the ratio characteristic test
// Assumes: phasor components valid in the cycle of start_i
// Notes: magnitudes one cycle after start, decision one more later
`timescale 1ns/1ps
`default_nettype none
module ratio_phase_eval
  import ratio_current_ratio_element_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic signed [CUR_W-1:0] neu_re_i,
  input wire logic signed [CUR_W-1:0] neu_im_i,
  input wire logic signed [CUR_W-1:0] out_re_i,
  input wire logic signed [CUR_W-1:0] out_im_i,
  input wire logic [1:0] meth_i,
  input wire logic [3:0] opcur_i,
  input wire logic [5:0] k1_i,
  input wire logic [5:0] k2_i,
  input wire logic [6:0] brk_i,
  output logic op_o
);
  logic signed [CUR_W:0] a_re, a_im, b_re, b_im;
  logic [SQ_W-1:0] d_sq;
  logic [MAG_W-1:0] d_q, a_q, b_q, s_q, restr;
  logic v_q, op_q;
  logic [WIDE_W-1:0] d_pct, is_c, r_w, k1_term, k2_term, min_c;
  logic low_reg, slope_ok, min_ok;

  assign a_re = (CUR_W+1)'(neu_re_i);
  assign a_im = (CUR_W+1)'(neu_im_i);
  assign b_re = (CUR_W+1)'(out_re_i);
  assign b_im = (CUR_W+1)'(out_im_i);
  assign d_sq = sq_mag(a_re - b_re, a_im - b_im);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      d_q <= '0;
      a_q <= '0;
      b_q <= '0;
      s_q <= '0;
      v_q <= 1'b0;
    end else begin
      v_q <= start_i;
      if (start_i) begin
        d_q <= isqrt(d_sq);
        a_q <= isqrt(sq_mag(a_re, a_im));
        b_q <= isqrt(sq_mag(b_re, b_im));
        s_q <= isqrt(sq_mag(a_re + b_re, a_im + b_im));
      end
    end
  end

  // Unused method code falls back to the greater magnitude
  assign restr = (meth_i == METH_MIN) ? ((a_q < b_q) ? a_q : b_q) :
                 (meth_i == METH_SUM) ? s_q :
                 ((a_q > b_q) ? a_q : b_q);
  assign d_pct = WIDE_W'(d_q) * WIDE_W'(PCT_FULL);
  assign is_c = WIDE_W'(brk_i) * WIDE_W'(DECI_TO_CENTI);
  assign r_w = WIDE_W'(restr);
  assign low_reg = r_w <= is_c;
  assign k1_term = WIDE_W'(k1_i) * r_w;
  assign k2_term = WIDE_W'(k2_i) * (r_w - is_c)
                 + WIDE_W'(k1_i) * is_c;
  assign slope_ok = low_reg ? (d_pct >= k1_term) : (d_pct >= k2_term);
  assign min_c = WIDE_W'(opcur_i) * WIDE_W'(DECI_TO_CENTI);
  assign min_ok = WIDE_W'(d_q) >= min_c;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_q <= 1'b0;
    end else if (v_q) begin
      op_q <= slope_ok & min_ok;
    end
  end
  assign op_o = op_q;

  property p_current_ratio_element_mag;
    @(posedge clk_i) disable iff (rst_i)
    start_i |=> (SQ_W'(d_q) * SQ_W'(d_q) <= $past(d_sq)) &&
      ((SQ_W'(d_q) + 1) * (SQ_W'(d_q) + 1) > $past(d_sq));
  endproperty
  a_current_ratio_element_mag: assert property (p_current_ratio_element_mag)
    else $error("difference magnitude wrong");

  property p_sum_restr;
    @(posedge clk_i) disable iff (rst_i)
    (meth_i == METH_SUM) |-> restr == s_q;
  endproperty
  a_sum_restr: assert property (p_sum_restr)
    else $error("sum restraint not selected");

  property p_op_min;
    @(posedge clk_i) disable iff (rst_i)
    v_q ##1 op_q |-> WIDE_W'($past(d_q)) >= $past(min_c);
  endproperty
  a_op_min: assert property (p_op_min)
    else $error("operated below minimum current");

  property p_low_slope;
    @(posedge clk_i) disable iff (rst_i)
    v_q && low_reg |=> op_q == ($past(d_pct) >= $past(k1_term) &&
      $past(min_ok));
  endproperty
  a_low_slope: assert property (p_low_slope)
    else $error("low region slope decision wrong");

  property p_high_slope;
    @(posedge clk_i) disable iff (rst_i)
    v_q && !low_reg && !slope_ok |=> !op_q;
  endproperty
  a_high_slope: assert property (p_high_slope)
    else $error("high region operated below slope");
endmodule
`default_nettype wire

// *** testbench/ct_front_end.sv ***
// Purpose: current transformer front end delivering phasor samples
// Assumes: bench sets per-phase phasors and holds them between samples
// Notes: strobe every SPACING cycles; data toggles between strobes
`timescale 1ns/1ps
`default_nettype none
module ct_front_end
  import ratio_current_ratio_element_pkg::*;
#(
  parameter int SPACING = 4
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [CUR_W-1:0] n_i [PHASES][2],
  input wire logic signed [CUR_W-1:0] o_i [PHASES][2],
  output logic valid_o,
  output logic signed [CUR_W-1:0] neu_o [PHASES][2],
  output logic signed [CUR_W-1:0] out_o [PHASES][2]
);
  logic [3:0] cnt_q;
  // ----------------------------------------------------------------
  // Sampling tick, six currents per tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      valid_o <= 1'b0;
      neu_o <= '{default: '0};
      out_o <= '{default: '0};
    end else begin
      cnt_q <= (cnt_q == 4'(SPACING - 1)) ? '0 : cnt_q + 4'h1;
      valid_o <= (cnt_q == '0);
      // Off-strobe data inverted so stale values never look valid
      for (int p = 0; p < PHASES; p++) begin
        for (int c = 0; c < 2; c++) begin
          neu_o[p][c] <= (cnt_q == '0) ? n_i[p][c] : ~neu_o[p][c];
          out_o[p][c] <= (cnt_q == '0) ? o_i[p][c] : ~out_o[p][c];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/current_ratio_differential_trip_bench.sv ***
// Purpose: self-checking bench of the ratio differential trip element
// Assumes: zero-wait APB slave, timer tick shortened to TICK cycles
// Notes: latencies checked in windows; the tick phase restarts at each state change
`timescale 1ns/1ps
`default_nettype none
module current_ratio_differential_trip_bench
  import ratio_current_ratio_element_pkg::*;
;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic lock1 = 1'b0;
  logic lock2 = 1'b0;
  logic signed [CUR_W-1:0] nq [PHASES][2] = '{default: '0};
  logic signed [CUR_W-1:0] oq [PHASES][2] = '{default: '0};
  logic signed [CUR_W-1:0] neu [PHASES][2];
  logic signed [CUR_W-1:0] outs [PHASES][2];
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic valid;
  logic [PHASES-1:0] phase_op;
  logic trip;
  logic irq;
  int errors = 0;
  int num_checks = 0;
  int c;
  logic [31:0] v;
  logic e;
  // nr ni or oi method phase op
  int tv [10][7] = '{'{200, 0, 200, 0, 0, 0, 0}, '{100, 0, 50, 0, 0, 1, 1},
    '{30, 0, 0, 0, 0, 2, 0}, '{40, 0, 0, 0, 0, 0, 1},
    '{500, 0, 400, 0, 0, 1, 0}, '{500, 0, 400, 0, 1, 2, 1},
    '{500, 0, 400, 0, 2, 0, 0}, '{100, 0, -50, 0, 2, 1, 1},
    '{60, 80, 60, 0, 0, 2, 1}, '{500, 0, 400, 0, 3, 0, 0}};
  logic [11:0] ra [8] = '{OFS_CTRL, OFS_OPCUR, OFS_SLOPE, OFS_BREAK,
    OFS_DELAY, OFS_EVT_EN, OFS_EVT, OFS_STAT};
  logic [31:0] rv [8] = '{32'h0, 32'h4, 32'h505, 32'hA, 32'h0, 32'h0,
    32'h0, 32'h0};

  initial begin
    forever #4 clk = ~clk;
  end

  ct_front_end ct_front_end_i (.clk_i(clk), .rst_i(rst), .n_i(nq),
    .o_i(oq), .valid_o(valid), .neu_o(neu), .out_o(outs));

  ratio_current_ratio_element_trip #(.TICK_CYCLES(TICK)) ratio_current_ratio_element_trip_i (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SAMPLE_VALID_I(valid),
    .I1A_RE_I(outs[0][0]), .I1A_IM_I(outs[0][1]),
    .I1B_RE_I(outs[1][0]), .I1B_IM_I(outs[1][1]),
    .I1C_RE_I(outs[2][0]), .I1C_IM_I(outs[2][1]),
    .I2A_RE_I(neu[0][0]), .I2A_IM_I(neu[0][1]),
    .I2B_RE_I(neu[1][0]), .I2B_IM_I(neu[1][1]),
    .I2C_RE_I(neu[2][0]), .I2C_IM_I(neu[2][1]),
    .INTERLOCK1_I(lock1), .INTERLOCK2_I(lock2),
    .PHASE_OP_O(phase_op), .TRIP_O(trip), .IRQ_O(irq));

  // ----------------------------------------------------------------
  // Access and comparison tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, v, e);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] msk, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, v, e);
    chk(nm, ex, v & msk);
  endtask

  // Phase p gets the phasors, the others zero; p < 0 clears all
  task automatic setp(input int p, input int a, input int b, input int x,
    input int y);
    @(posedge clk);
    for (int k = 0; k < PHASES; k++) begin
      nq[k][0] <= (k == p) ? CUR_W'(a) : '0;
      nq[k][1] <= (k == p) ? CUR_W'(b) : '0;
      oq[k][0] <= (k == p) ? CUR_W'(x) : '0;
      oq[k][1] <= (k == p) ? CUR_W'(y) : '0;
    end
  endtask

  // sel 0 watches the trip output, sel 1 any phase decision
  task automatic until_sig(input int sel, input logic lv, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (((sel == 0) ? trip : |phase_op) !== lv && n < 400);
    chk("wait_level", 32'(lv), 32'((sel == 0) ? trip : |phase_op));
  endtask

  initial begin
    #400000;
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdc("reg_reset", ra[i], 32'hFFFFFFFF, rv[i]);
      chk("reg_err", 32'h0, e);
    end
    rdc("unmapped", 12'h100, 32'hFFFFFFFF, 32'h0);
    chk("unmapped_err", 32'h1, e);
    wr(OFS_SLOPE, 32'h0000_1E0A);
    for (int i = 0; i < 10; i++) begin
      wr(OFS_CTRL, 32'(tv[i][4] << 1));
      setp(tv[i][5], tv[i][0], tv[i][1], tv[i][2], tv[i][3]);
      repeat (12) @(posedge clk);
      chk("phase_op", 32'(tv[i][6] << tv[i][5]), phase_op);
      chk("trip_unused", 32'h0, trip);
    end
    setp(-1, 0, 0, 0, 0);
    wr(OFS_EVT_EN, 32'h1);
    wr(OFS_CTRL, 32'h1);
    setp(2, 100, 0, 50, 0);
    until_sig(1, 1'b1, c);
    until_sig(0, 1'b1, c);
    chk("trip_instantaneous_setting", 32'h1, 32'(c <= 3));
    repeat (3) @(posedge clk);
    chk("irq_on", 32'h1, irq);
    rdc("evt_rose", OFS_EVT, 32'h7, 32'h1);
    rdc("stat", OFS_STAT, 32'h3F, 32'h0C);
    wr(OFS_EVT_CLR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, irq);
    setp(-1, 0, 0, 0, 0);
    until_sig(1, 1'b0, c);
    until_sig(0, 1'b0, c);
    chk("off_delay", 32'h1, 32'(c >= (OFF_DELAY_TICKS - 1) * TICK &&
      c <= (OFF_DELAY_TICKS + 1) * TICK + 3));
    chk("irq_masked", 32'h0, irq);
    rdc("evt_fell", OFS_EVT, 32'h7, 32'h2);
    wr(OFS_EVT_CLR, 32'h2);
    wr(OFS_DELAY, 32'h2);
    setp(0, 100, 0, 50, 0);
    until_sig(1, 1'b1, c);
    until_sig(0, 1'b1, c);
    chk("op_delay", 32'h1, 32'(c >= 2 * TICK && c <= 2 * TICK + 3));
    setp(-1, 0, 0, 0, 0);
    until_sig(0, 1'b0, c);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lock1 <= (k == 0);
      lock2 <= (k == 1);
      setp(1, 100, 0, 50, 0);
      repeat (40) @(posedge clk);
      chk("trip_locked", 32'h0, trip);
      rdc("stat_lock", OFS_STAT, 32'h3F, 32'(1 << (4 + k)) | 32'h2);
      rdc("evt_blk", OFS_EVT, 32'h4, 32'h4);
    end
    wr(OFS_EVT_EN, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq_blk", 32'h1, irq);
    setp(-1, 0, 0, 0, 0);
    repeat (12) @(posedge clk);
    lock2 <= 1'b0;
    wr(OFS_EVT_CLR, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq_blk_clr", 32'h0, irq);
    setp(0, 100, 0, 50, 0);
    until_sig(0, 1'b1, c);
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("trip_use_off", 32'h0, trip);
    setp(-1, 0, 0, 0, 0);
    results();
  end
endmodule
`default_nettype wire
